// [hdl/ssp_pkg.sv]
// shared types and constants for the serial/shared-pin port block
// assumes a 40 MHz core clock and a separately clocked serial link
package ssp_pkg;
  localparam int unsigned SSP_CLK_PERIOD_NS = 25;
  localparam int unsigned SSP_WORD_W = 8;
  localparam int unsigned SSP_FIFO_DEPTH = 8;
  localparam int unsigned SSP_BIT_CNT_W = 3;
  localparam logic [2:0] SSP_BIT_CNT_LAST = 3'h7;
  localparam logic [3:0] SSP_GPIO_SEL_RST = 4'h0;
  localparam logic [3:0] SSP_GPIO_OE_N_RST = 4'hF;
  localparam logic [3:0] SSP_GPIO_OUT_RST = 4'h0;
  localparam logic SSP_SECOND_SEL_RST = 1'b0;
  localparam logic [3:0] SSP_DIV_HALF = 4'h3;
  localparam logic [3:0] SSP_PIN_SYNC_RST = 4'h8;
  localparam logic [1:0] SSP_RX_SYNC_RST = 2'h3;

  typedef enum logic [1:0]
  {
    SSP_ST_IDLE = 2'b00,
    SSP_ST_SHIFT = 2'b01,
    SSP_ST_DONE = 2'b10
  } ssp_state_t;

  typedef struct packed
  {
    logic in;
    logic out;
    logic oe_n;
  } ssp_pin_t;

  typedef struct packed
  {
    logic [3:0] sel_gpio;
    logic [3:0] oe_n;
    logic [3:0] out;
  } ssp_gpio_cfg_t;
endpackage

// [hdl/ssp_fifo.sv]
// synchronous fifo with valid/ready on both sides
// assumes a single clock; width and depth set by parameters
module ssp_fifo
  import ssp_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic ready_r;
  logic push;
  logic pop;

  // ready is registered so the fill side sees no combinational path
  assign push = in_valid_i && ready_r;
  assign pop = (count_r != '0) && out_ready_i;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_o = ready_r;
  assign out_valid_o = count_r != '0;
  assign out_data_o = mem_r[rd_ptr_r];

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
      ready_r <= count_nxt != (AW+1)'(DEPTH);
    end
  end
endmodule

// [hdl/ssp_port.sv]
// first serial port pins with shared general-purpose use, plus second-port pin mux
// assumes spi mode 0, msb first; link clock is the slave-side spi clock domain
module ssp_port
  import ssp_pkg::*;
#(
  parameter int unsigned WIDTH = SSP_WORD_W,
  parameter int unsigned DEPTH = SSP_FIFO_DEPTH
)
(
  // clocks and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic spi_link_clk_i,
  // configuration
  input wire logic master_mode_i,
  input wire logic second_spi_sel_i,
  input wire logic cfg_load_i,
  input wire ssp_gpio_cfg_t gpio_cfg_i,
  // transmit stream
  input wire logic tx_valid_i,
  input wire logic [WIDTH-1:0] tx_data_i,
  output logic tx_ready_o,
  // receive stream
  output logic rx_valid_o,
  output logic [WIDTH-1:0] rx_data_o,
  input wire logic rx_ready_i,
  // status
  output logic mode_fault_o,
  output logic [3:0] gpio_in_o,
  // first port pins: clock, master out, master in, select
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic select_n_i,
  output logic select_n_o,
  output logic select_oe_n_o,
  // second port pins
  output logic async_tx_out_a_o,
  output logic async_tx_out_a_oe_n_o,
  input wire logic async_rx_in_a_i,
  output logic async_tx_out_b_o,
  output logic async_tx_out_b_oe_n_o,
  input wire logic async_rx_in_b_i,
  // second port internal users
  input wire logic async_tx_a_i,
  input wire logic async_tx_b_i,
  output logic async_rx_a_o,
  output logic async_rx_b_o,
  input wire logic second_spi_clock_i,
  input wire logic second_spi_clock_oe_i,
  input wire logic second_spi_master_in_i,
  input wire logic second_spi_master_in_oe_i,
  output logic second_spi_master_out_o,
  output logic second_spi_select_n_o
);
  // ------------------------------------------------------------
  // pin synchronisers and configuration
  // ------------------------------------------------------------
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic [1:0] rx2_meta_r;
  logic [1:0] rx2_sync_r;
  logic [3:0] sel_gpio_r;
  logic [3:0] gpio_oe_n_r;
  logic [3:0] gpio_out_r;
  logic second_sel_r;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // idle levels, so no false select or start bit follows reset
      pin_meta_r <= SSP_PIN_SYNC_RST;
      pin_sync_r <= SSP_PIN_SYNC_RST;
      rx2_meta_r <= SSP_RX_SYNC_RST;
      rx2_sync_r <= SSP_RX_SYNC_RST;
    end
    else
    begin
      pin_meta_r <= {select_n_i, miso_i, mosi_i, sclk_i};
      pin_sync_r <= pin_meta_r;
      rx2_meta_r <= {async_rx_in_b_i, async_rx_in_a_i};
      rx2_sync_r <= rx2_meta_r;
    end
  end

  // serial function is the reset default on all four pins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_gpio_r <= SSP_GPIO_SEL_RST;
      gpio_oe_n_r <= SSP_GPIO_OE_N_RST;
      gpio_out_r <= SSP_GPIO_OUT_RST;
    end
    else if (cfg_load_i)
    begin
      sel_gpio_r <= gpio_cfg_i.sel_gpio;
      gpio_oe_n_r <= gpio_cfg_i.oe_n;
      gpio_out_r <= gpio_cfg_i.out;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      second_sel_r <= SSP_SECOND_SEL_RST;
    end
    else
    begin
      second_sel_r <= second_spi_sel_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gpio_in_o <= '0;
    end
    else
    begin
      gpio_in_o <= pin_sync_r;
    end
  end

  // ------------------------------------------------------------
  // fifos
  // ------------------------------------------------------------
  logic txf_valid;
  logic [WIDTH-1:0] txf_data;
  logic txf_pop;
  logic rxf_push;
  logic [WIDTH-1:0] rxf_data;
  logic rxf_ready;
  logic rxf_valid;
  logic [WIDTH-1:0] rxf_out;
  logic rx_take;

  ssp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_txf
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(txf_valid),
    .out_data_o(txf_data),
    .out_ready_i(txf_pop)
  );

  ssp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rxf
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rxf_push),
    .in_data_i(rxf_data),
    .in_ready_o(rxf_ready),
    .out_valid_o(rxf_valid),
    .out_data_o(rxf_out),
    .out_ready_i(rx_take)
  );

  // registered output stage; pops when empty or consumed
  assign rx_take = rxf_valid && (!rx_valid_o || rx_ready_i);

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end
    else if (rx_take)
    begin
      rx_valid_o <= 1'b1;
      rx_data_o <= rxf_out;
    end
    else if (rx_ready_i)
    begin
      rx_valid_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // master engine on the core clock
  // ------------------------------------------------------------
  ssp_state_t state_r;
  logic [3:0] div_r;
  logic [SSP_BIT_CNT_W-1:0] bit_r;
  logic [WIDTH-1:0] msh_r;
  logic mclk_r;
  logic fault_set;
  logic miso_smp_r;
  logic [WIDTH-1:0] slv_word_r;
  logic slv_word_evt;

  // select pulled low by another master while we own the bus
  assign fault_set = master_mode_i && !sel_gpio_r[3] && !pin_sync_r[3];
  assign txf_pop = master_mode_i && (state_r == SSP_ST_IDLE) && txf_valid && rxf_ready
    && !mode_fault_o;
  assign rxf_push = (master_mode_i && state_r == SSP_ST_DONE) || slv_word_evt;
  assign rxf_data = master_mode_i ? msh_r : slv_word_r;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_fault_o <= 1'b0;
    end
    else if (fault_set)
    begin
      mode_fault_o <= 1'b1;
    end
    else if (!master_mode_i)
    begin
      mode_fault_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= SSP_ST_IDLE;
      div_r <= '0;
      bit_r <= '0;
      msh_r <= '0;
      mclk_r <= 1'b0;
      miso_smp_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        SSP_ST_IDLE:
        begin
          mclk_r <= 1'b0;
          div_r <= '0;
          bit_r <= '0;
          if (txf_pop)
          begin
            msh_r <= txf_data;
            state_r <= SSP_ST_SHIFT;
          end
        end
        SSP_ST_SHIFT:
        begin
          if (fault_set)
          begin
            state_r <= SSP_ST_IDLE;
          end
          else if (div_r == SSP_DIV_HALF)
          begin
            div_r <= '0;
            mclk_r <= !mclk_r;
            if (!mclk_r)
            begin
              // sample on the rise, shift on the fall: mosi never moves at a rise
              miso_smp_r <= pin_sync_r[2];
            end
            else
            begin
              msh_r <= {msh_r[WIDTH-2:0], miso_smp_r};
              if (bit_r == SSP_BIT_CNT_LAST)
              begin
                state_r <= SSP_ST_DONE;
              end
              else
              begin
                bit_r <= bit_r + 3'h1;
              end
            end
          end
          else
          begin
            div_r <= div_r + 4'h1;
          end
        end
        SSP_ST_DONE:
        begin
          state_r <= SSP_ST_IDLE;
        end
        default:
        begin
          state_r <= SSP_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // slave engine on the link clock
  // ------------------------------------------------------------
  logic [WIDTH-1:0] ssh_r;
  logic [SSP_BIT_CNT_W-1:0] sbit_r;
  logic slv_tog_r;
  logic [2:0] tog_sync_r;
  logic [WIDTH-1:0] stx_r;
  logic smiso_r;

  // link clock only runs while selected; deselect clears the bit count
  always_ff @(posedge spi_link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ssh_r <= '0;
      sbit_r <= '0;
      slv_word_r <= '0;
      slv_tog_r <= 1'b0;
    end
    else if (select_n_i)
    begin
      sbit_r <= '0;
    end
    else
    begin
      ssh_r <= {ssh_r[WIDTH-2:0], mosi_i};
      sbit_r <= sbit_r + 3'h1;
      if (sbit_r == SSP_BIT_CNT_LAST)
      begin
        slv_word_r <= {ssh_r[WIDTH-2:0], mosi_i};
        slv_tog_r <= !slv_tog_r;
      end
    end
  end

  // slave reply word: echoes last received word, shifted on the falling edge
  always_ff @(negedge spi_link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stx_r <= '0;
      smiso_r <= 1'b0;
    end
    else
    begin
      smiso_r <= (sbit_r == '0) ? slv_word_r[WIDTH-1] : stx_r[WIDTH-1];
      stx_r <= (sbit_r == '0) ? {slv_word_r[WIDTH-2:0], 1'b0} : {stx_r[WIDTH-2:0], 1'b0};
    end
  end

  // toggle crossing; word register is stable for a full byte after the toggle
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tog_sync_r <= '0;
    end
    else
    begin
      tog_sync_r <= {tog_sync_r[1:0], slv_tog_r};
    end
  end
  assign slv_word_evt = !master_mode_i && (tog_sync_r[2] != tog_sync_r[1]);

  // ------------------------------------------------------------
  // pin drivers (enables active low)
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_o <= 1'b0;
      sclk_oe_n_o <= 1'b1;
      mosi_o <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
      select_n_o <= 1'b1;
      select_oe_n_o <= 1'b1;
    end
    else
    begin
      sclk_o <= sel_gpio_r[0] ? gpio_out_r[0] : mclk_r;
      sclk_oe_n_o <= sel_gpio_r[0] ? gpio_oe_n_r[0] : !master_mode_i;
      mosi_o <= sel_gpio_r[1] ? gpio_out_r[1] : msh_r[WIDTH-1];
      mosi_oe_n_o <= sel_gpio_r[1] ? gpio_oe_n_r[1] : !master_mode_i;
      miso_o <= sel_gpio_r[2] ? gpio_out_r[2] : smiso_r;
      // slave drives only while selected, else high impedance
      miso_oe_n_o <= sel_gpio_r[2] ? gpio_oe_n_r[2]
        : (master_mode_i || pin_sync_r[3]);
      select_n_o <= gpio_out_r[3];
      select_oe_n_o <= sel_gpio_r[3] ? gpio_oe_n_r[3] : 1'b1;
    end
  end

  // second port: async by default, alternate second spi
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      async_tx_out_a_o <= 1'b1;
      async_tx_out_a_oe_n_o <= 1'b0;
      async_tx_out_b_o <= 1'b1;
      async_tx_out_b_oe_n_o <= 1'b0;
      async_rx_a_o <= 1'b1;
      async_rx_b_o <= 1'b1;
      second_spi_master_out_o <= 1'b0;
      second_spi_select_n_o <= 1'b1;
    end
    else
    begin
      async_tx_out_a_o <= second_sel_r ? second_spi_clock_i : async_tx_a_i;
      async_tx_out_a_oe_n_o <= second_sel_r ? !second_spi_clock_oe_i : 1'b0;
      async_tx_out_b_o <= second_sel_r ? second_spi_master_in_i : async_tx_b_i;
      async_tx_out_b_oe_n_o <= second_sel_r ? !second_spi_master_in_oe_i : 1'b0;
      async_rx_a_o <= second_sel_r ? 1'b1 : rx2_sync_r[0];
      async_rx_b_o <= second_sel_r ? 1'b1 : rx2_sync_r[1];
      second_spi_master_out_o <= second_sel_r ? rx2_sync_r[0] : 1'b0;
      second_spi_select_n_o <= second_sel_r ? rx2_sync_r[1] : 1'b1;
    end
  end
endmodule

// [bench/ssp_port_checker.sv]
// concurrent checks on the serial/shared-pin port pins
// assumes one core clock domain; bound into every ssp_port
module ssp_port_checker
  import ssp_pkg::*;
#(
  parameter int unsigned WIDTH = SSP_WORD_W,
  parameter int unsigned DEPTH = SSP_FIFO_DEPTH
)
(
  // clock, reset, configuration
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic master_mode_i,
  input wire logic second_spi_sel_i,
  input wire logic cfg_load_i,
  input wire ssp_gpio_cfg_t gpio_cfg_i,
  // stream and status
  input wire logic rx_valid_o,
  input wire logic [WIDTH-1:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic mode_fault_o,
  // pins
  input wire logic select_n_i,
  input wire logic sclk_o,
  input wire logic sclk_oe_n_o,
  input wire logic mosi_o,
  input wire logic miso_oe_n_o,
  input wire logic async_tx_out_a_o,
  input wire logic async_tx_out_a_oe_n_o,
  input wire logic async_tx_out_b_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // shadow of the pin-function selection
  // ----
  logic [3:0] gsel_r;
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      gsel_r <= SSP_GPIO_SEL_RST;
    else if (cfg_load_i)
      gsel_r <= gpio_cfg_i.sel_gpio;
  // ----
  // properties
  // ----
  a_reset_pins: assert property (
    $rose(rst_n_i) |-> miso_oe_n_o && sclk_oe_n_o && !async_tx_out_a_oe_n_o
      && async_tx_out_a_o && !mode_fault_o) else $error("pin defaults wrong after reset");
  a_miso_idle: assert property (
    (!master_mode_i && select_n_i && !gsel_r[2]) [*5] |-> miso_oe_n_o)
    else $error("miso driven while unselected");
  a_miso_master_in: assert property (
    (master_mode_i && !gsel_r[2]) [*3] |-> miso_oe_n_o) else $error("miso driven as master");
  a_sclk_master_out: assert property (
    (master_mode_i && !mode_fault_o && !gsel_r[0]) [*3] |-> !sclk_oe_n_o)
    else $error("clock not driven as master");
  a_sclk_slave_in: assert property (
    (!master_mode_i && !gsel_r[0]) [*3] |-> sclk_oe_n_o) else $error("clock driven as slave");
  a_fault_set: assert property (
    (master_mode_i && !select_n_i && !gsel_r[3]) [*6] |-> mode_fault_o)
    else $error("contention not flagged");
  a_fault_clear: assert property (
    !master_mode_i [*3] |-> !mode_fault_o) else $error("fault outside master mode");
  a_mosi_before_rise: assert property (
    master_mode_i && $rose(sclk_o) |-> $stable(mosi_o)) else $error("mosi moved at clock rise");
  a_async_default: assert property (
    !second_spi_sel_i [*3] |-> !async_tx_out_a_oe_n_o && !async_tx_out_b_oe_n_o)
    else $error("async transmit pins released");
  a_rx_hold: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o)) else $error("rx word dropped");
endmodule

bind ssp_port ssp_port_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_ssp_port_checker (.*);

// [bench/ssp_spi_peer.sv]
// behavioural spi peer: slave when the port is master, else master
// assumes mode 0, msb first; link clock 64 ns, still outside frames
module ssp_spi_peer
(
  // board pins as resolved
  input wire logic pin_sck_i,
  input wire logic pin_mosi_i,
  input wire logic pin_miso_i,
  input wire logic slave_en_i,
  // levels driven by the peer
  output logic miso_o,
  output logic sck_o,
  output logic mosi_o,
  output logic ss_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh, rep, heard;
  logic [7:0] got[$];
  int n, nb;
  initial
  begin
    {sck_o, mosi_o, ss_n_o} = 3'h1;
    n = 0;
    nb = 0;
    rep = 8'h3C;
    miso_o = rep[7];
  end
  // ----
  // slave side
  // ----
  always @(posedge pin_sck_i)
    if (slave_en_i)
    begin
      sh = {sh[6:0], pin_mosi_i};
      nb++;
      if (nb == 8)
      begin
        got.push_back(sh);
        nb = 0;
        n++;
        rep = 8'(n * 8'h1D + 8'h3C);
      end
    end
  // next bit on the fall, half a cycle ahead of the rise
  always @(negedge pin_sck_i)
    if (slave_en_i)
      miso_o <= rep[3'(7 - nb)];
  // ----
  // master side
  // ----
  always @(posedge pin_sck_i)
    if (!ss_n_o)
      heard <= {heard[6:0], pin_miso_i};
  task automatic frame(input logic [7:0] w);
    ss_n_o = 0;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      mosi_o = w[i];
      #32 sck_o = 1;
      #32 sck_o = 0;
    end
    #100;
    ss_n_o = 1;
    mosi_o = ~mosi_o;
  endtask
endmodule

// [bench/ssp_port_tb.sv]
// self-checking bench for the serial/shared-pin port
// assumes the peer model and the bound checker
module ssp_port_tb
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i, rst_n_i, spi_link_clk_i, master_mode_i, second_spi_sel_i, cfg_load_i;
  ssp_gpio_cfg_t gpio_cfg_i;
  logic tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i, mode_fault_o;
  logic [7:0] tx_data_i, rx_data_o, d, v, w;
  logic [3:0] gpio_in_o, far;
  logic sclk_i, sclk_o, sclk_oe_n_o, mosi_i, mosi_o, mosi_oe_n_o, miso_i, miso_o, miso_oe_n_o;
  logic select_n_i, select_n_o, select_oe_n_o, p_sck, p_mosi, p_miso, p_ss_n;
  logic async_tx_out_a_o, async_tx_out_a_oe_n_o, async_rx_in_a_i, async_tx_out_b_o;
  logic async_tx_out_b_oe_n_o, async_rx_in_b_i, async_tx_a_i, async_tx_b_i, async_rx_a_o;
  logic async_rx_b_o, second_spi_clock_i, second_spi_clock_oe_i, second_spi_master_in_i;
  logic second_spi_master_in_oe_i, second_spi_master_out_o, second_spi_select_n_o;
  int errors, comparisons, n;
  bit ok;
  logic [7:0] sent[$];
  assign sclk_i = sclk_oe_n_o ? p_sck : sclk_o;
  assign spi_link_clk_i = p_sck;
  assign mosi_i = mosi_oe_n_o ? p_mosi : mosi_o;
  assign miso_i = miso_oe_n_o ? p_miso : miso_o;
  assign select_n_i = select_oe_n_o ? p_ss_n : select_n_o;
  ssp_port i_ssp_port (.*);
  ssp_spi_peer i_ssp_spi_peer (.pin_sck_i(sclk_i), .pin_mosi_i(mosi_i), .pin_miso_i(miso_i),
    .slave_en_i(master_mode_i), .miso_o(p_miso), .sck_o(p_sck), .mosi_o(p_mosi),
    .ss_n_o(p_ss_n));
  initial
  begin
    clock_i = 0;
    forever #12.5 clock_i = ~clock_i;
  end
  // ----
  // expectations and bus helpers
  // ----
  function automatic logic [7:0] reply(int k);
    return 8'(k * 8'h1D + 8'h3C);
  endfunction
  function automatic logic [3:0] pins(ssp_gpio_cfg_t c, logic [3:0] f);
    return (c.oe_n & f) | (~c.oe_n & c.out);
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clock_i);
    #2;
  endtask
  task automatic getrx(output logic [7:0] q);
    int i;
    for (i = 0; i < 1500 && rx_valid_o !== 1'b1; i++)
      step(1);
    if (i == 1500)
    begin
      chk("rx_valid_o", 8'h0, 8'h1);
      results();
    end
    q = rx_data_o;
    rx_ready_i = 1;
    step(1);
    rx_ready_i = 0;
    step(1);
  endtask
  task automatic push(input logic [7:0] q, output bit acc);
    tx_valid_i = 1;
    tx_data_i = q;
    acc = tx_ready_o;
    step(1);
  endtask
  task automatic load(input ssp_gpio_cfg_t c);
    gpio_cfg_i = c;
    cfg_load_i = 1;
    step(1);
    cfg_load_i = 0;
    step(5);
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    {rst_n_i, master_mode_i, second_spi_sel_i, cfg_load_i, tx_valid_i, rx_ready_i} = 6'h0;
    {async_rx_in_a_i, async_rx_in_b_i, async_tx_a_i, async_tx_b_i} = 4'hF;
    {second_spi_clock_i, second_spi_clock_oe_i, second_spi_master_in_i} = 3'h0;
    second_spi_master_in_oe_i = 0;
    gpio_cfg_i = '{SSP_GPIO_SEL_RST, SSP_GPIO_OE_N_RST, SSP_GPIO_OUT_RST};
    tx_data_i = 8'h00;
    errors = 0;
    comparisons = 0;
    void'($urandom(66452));
    step(10);
    chk("miso_oe_n", miso_oe_n_o, 8'h1);
    chk("sclk_oe_n", sclk_oe_n_o, 8'h1);
    chk("tx_a_oe_n", async_tx_out_a_oe_n_o, 8'h0);
    step(10);
    rst_n_i = 1;
    step(2);
    repeat (4)
    begin
      {async_rx_in_a_i, async_rx_in_b_i, async_tx_a_i, async_tx_b_i} = 4'($urandom);
      step(4);
      chk("rx_a", async_rx_a_o, async_rx_in_a_i);
      chk("rx_b", async_rx_b_o, async_rx_in_b_i);
      chk("tx_a", async_tx_out_a_o, async_tx_a_i);
      chk("tx_b", async_tx_out_b_o, async_tx_b_i);
    end
    second_spi_sel_i = 1;
    repeat (4)
    begin
      far = 4'($urandom);
      {second_spi_clock_i, second_spi_master_in_i, async_rx_in_a_i, async_rx_in_b_i} = far;
      {second_spi_clock_oe_i, second_spi_master_in_oe_i} = 2'($urandom);
      step(4);
      chk("tx_a_oe_n", async_tx_out_a_oe_n_o, !second_spi_clock_oe_i);
      chk("tx_b_oe_n", async_tx_out_b_oe_n_o, !second_spi_master_in_oe_i);
      chk("spi_mo", second_spi_master_out_o, far[1]);
      chk("spi_sel", second_spi_select_n_o, far[0]);
      chk("spi_clk", async_tx_out_a_o, far[3]);
      chk("spi_mi", async_tx_out_b_o, far[2]);
      chk("rx_a_idle", async_rx_a_o, 8'h1);
    end
    second_spi_sel_i = 0;
    step(5);
    chk("miso_oe_n", miso_oe_n_o, 8'h1);
    for (int k = 0; k < 3; k++)
    begin
      v = d;
      d = 8'($urandom);
      fork
        i_ssp_spi_peer.frame(d);
        begin
          step(16);
          chk("miso_oe_n", miso_oe_n_o, 8'h0);
          chk("sclk_oe_n", sclk_oe_n_o, 8'h1);
        end
      join
      getrx(w);
      chk("rx_data", w, d);
      if (k > 0)
        chk("reply", i_ssp_spi_peer.heard, v);
    end
    // fill until refused while the port is slave and sends nothing
    ok = 1;
    for (n = 0; ok && n < 12; n += int'(ok))
    begin
      d = 8'($urandom);
      push(d, ok);
      if (ok)
        sent.push_back(d);
    end
    tx_valid_i = 0;
    chk("fill", 8'(n), 8'(SSP_FIFO_DEPTH));
    master_mode_i = 1;
    step(40);
    chk("sclk_oe_n", sclk_oe_n_o, 8'h0);
    chk("miso_oe_n", miso_oe_n_o, 8'h1);
    step(700);
    foreach (sent[k])
    begin
      getrx(w);
      chk("rx_data", w, reply(k));
      chk("peer_got", i_ssp_spi_peer.got[k], sent[k]);
    end
    chk("tx_ready", tx_ready_o, 8'h1);
    master_mode_i = 0;
    repeat (3)
    begin
      load('{4'hF, 4'($urandom), 4'($urandom)});
      far = {p_ss_n, p_miso, p_mosi, p_sck};
      chk("oe_n", {select_oe_n_o, miso_oe_n_o, mosi_oe_n_o, sclk_oe_n_o}, gpio_cfg_i.oe_n);
      chk("gpio_in", gpio_in_o, pins(gpio_cfg_i, far));
    end
    load('{SSP_GPIO_SEL_RST, SSP_GPIO_OE_N_RST, SSP_GPIO_OUT_RST});
    master_mode_i = 1;
    i_ssp_spi_peer.ss_n_o = 0;
    for (n = 0; n < 20 && mode_fault_o !== 1'b1; n++)
      step(1);
    chk("fault", mode_fault_o, 8'h1);
    i_ssp_spi_peer.ss_n_o = 1;
    master_mode_i = 0;
    step(4);
    chk("fault", mode_fault_o, 8'h0);
    results();
  end
endmodule
